// file: window_watchdog.sv
// window watchdog: free-running 7-bit downcounter with refresh window, APB slave
`timescale 1ns/100ps
module window_watchdog #(
    parameter int BASE_CYCLES = wwd_pkg::PRESC_BASE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic dbg_halt,
    input wire logic halt_freeze_cfg,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wdg_reset_req
);
    import wwd_pkg::*;

    logic arm_q, arm_d;
    logic [6:0] cnt_q, cnt_d;
    logic [6:0] win_q, win_d;
    logic [1:0] div_q, div_d;
    logic ewe_q, ewe_d;
    logic flag_q, flag_d;
    logic fault_q, fault_d;
    logic [EVT_W-1:0] en_q, en_d;
    logic [PRESC_W-1:0] pre_q, pre_d;
    logic rst_q, rst_d;
    logic irq_q, irq_d;
    logic rdy_q, rdy_d;
    logic err_q, err_d;
    logic [31:0] rd_q, rd_d;
    logic tick, wr, wr_ctrl, wr_cfg, wr_warn, wr_clr, wr_en, mapped;
    logic [PRESC_W-1:0] pre_last;
    logic [EVT_W-1:0] evt;

    // apb decode; a write lands at the edge where the access completes
    always_comb begin
        mapped = (paddr == OFF_CTRL) || (paddr == OFF_CFG) || (paddr == OFF_WARN)
            || (paddr == OFF_EVT) || (paddr == OFF_CLR) || (paddr == OFF_EN);
        wr = psel && penable && pwrite && rdy_q && mapped;
        wr_ctrl = wr && (paddr == OFF_CTRL);
        wr_cfg = wr && (paddr == OFF_CFG);
        wr_warn = wr && (paddr == OFF_WARN);
        wr_clr = wr && (paddr == OFF_CLR);
        wr_en = wr && (paddr == OFF_EN);
    end

    // prescaler; frozen while halted if so selected
    always_comb begin
        pre_last = PRESC_W'((BASE_CYCLES << div_q) - 1);
        tick = (pre_q == pre_last) && !(dbg_halt && halt_freeze_cfg);
        pre_d = pre_q;
        if (!(dbg_halt && halt_freeze_cfg)) begin
            // a counter write leaves the phase alone, so refresh timing jitters
            pre_d = tick ? '0 : pre_q + 1'b1;
            // a divider change can leave the phase above the new end; restart then,
            // but only while running, so a frozen phase stays put
            if (pre_q > pre_last) begin
                pre_d = '0;
            end
        end
    end

    // counter, arm latch, configuration
    always_comb begin
        arm_d = arm_q;
        cnt_d = cnt_q;
        win_d = win_q;
        div_d = div_q;
        ewe_d = ewe_q;
        if (tick) begin
            cnt_d = cnt_q - 1'b1;
        end
        if (wr_ctrl) begin
            cnt_d = pwdata[6:0];
            arm_d = arm_q | pwdata[CTRL_ARM_BIT];
        end
        if (wr_cfg) begin
            win_d = pwdata[6:0];
            div_d = pwdata[CFG_DIV_LSB +: 2];
            ewe_d = ewe_q | pwdata[CFG_EWE_BIT];
        end
    end

    // reset request: timeout, early refresh, or write with msb clear
    always_comb begin
        rst_d = 1'b0;
        if (arm_q && tick && !wr_ctrl && cnt_q == WARN_COUNT) begin
            rst_d = 1'b1;
        end
        if (wr_ctrl && arm_q && cnt_q > win_q) begin
            rst_d = 1'b1;
        end
        if (wr_ctrl && (arm_q | pwdata[CTRL_ARM_BIT]) && !pwdata[CNT_MSB_BIT]) begin
            rst_d = 1'b1;
        end
    end

    // warn flag and event status; a set in the clear cycle wins
    always_comb begin
        flag_d = flag_q;
        fault_d = fault_q;
        en_d = en_q;
        if (wr_warn && !pwdata[0]) begin
            flag_d = 1'b0;
        end
        if (wr_clr && pwdata[EVT_WARN_BIT]) begin
            flag_d = 1'b0;
        end
        if (wr_clr && pwdata[EVT_FAULT_BIT]) begin
            fault_d = 1'b0;
        end
        if (tick && !wr_ctrl && cnt_q == WARN_COUNT + 7'h01) begin
            flag_d = 1'b1;
        end
        // sticky record that this block asked for a system reset
        if (rst_d) begin
            fault_d = 1'b1;
        end
        if (wr_en) begin
            en_d = pwdata[EVT_W-1:0];
        end
        evt = {fault_q, flag_q};
        // warn request needs arm and warn enable; mask register gates both
        irq_d = (flag_q && ewe_q && arm_q && en_q[EVT_WARN_BIT])
            || (fault_q && en_q[EVT_FAULT_BIT]);
    end

    // read mux and apb answer one cycle into the access phase
    always_comb begin
        rdy_d = psel && penable && !rdy_q;
        err_d = psel && penable && !rdy_q && !mapped;
        rd_d = '0;
        if (psel && penable && !rdy_q && !pwrite) begin
            unique case (paddr)
                OFF_CTRL: rd_d = {24'h000000, arm_q, cnt_q};
                OFF_CFG: rd_d = {22'h000000, ewe_q, div_q, win_q};
                OFF_WARN: rd_d = {31'h00000000, flag_q};
                OFF_EVT: rd_d = {30'h00000000, evt};
                OFF_EN: rd_d = {30'h00000000, en_q};
                default: rd_d = '0; // clear register and unmapped read zero
            endcase
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= 1'b0;
            cnt_q <= COUNT_RST;
            win_q <= WINDOW_RST;
            div_q <= DIV_RST;
            ewe_q <= 1'b0;
            flag_q <= 1'b0;
            fault_q <= 1'b0;
            en_q <= EVT_EN_RST;
            pre_q <= '0;
            rst_q <= 1'b0;
            irq_q <= 1'b0;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= '0;
        end else begin
            arm_q <= arm_d;
            cnt_q <= cnt_d;
            win_q <= win_d;
            div_q <= div_d;
            ewe_q <= ewe_d;
            flag_q <= flag_d;
            fault_q <= fault_d;
            en_q <= en_d;
            pre_q <= pre_d;
            rst_q <= rst_d;
            irq_q <= irq_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            rd_q <= rd_d;
        end
    end

    assign prdata = rd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign irq = irq_q;
    assign wdg_reset_req = rst_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_timeout_reset: assert property (
        arm_q && tick && !wr_ctrl && cnt_q == WARN_COUNT |=> wdg_reset_req
    ) else $error("timeout did not raise reset");

    chk_early_refresh: assert property (
        wr_ctrl && arm_q && cnt_q > win_q |=> wdg_reset_req && cnt_q == $past(pwdata[6:0])
    ) else $error("early refresh did not raise reset");

    chk_arm_sticky: assert property (
        arm_q |=> arm_q
    ) else $error("arm latch cleared without reset");

    chk_count_steps: assert property (
        tick && !wr_ctrl |=> cnt_q == $past(cnt_q) - 7'h01
    ) else $error("counter missed a tick");

    chk_soft_reset: assert property (
        wr_ctrl && arm_q && !pwdata[CNT_MSB_BIT] |=> wdg_reset_req
    ) else $error("msb clear write did not reset");

    chk_warn_irq: assert property (
        flag_q && ewe_q && arm_q && en_q[EVT_WARN_BIT] |=> irq
    ) else $error("warn interrupt missing");

    chk_flag_hold: assert property (
        flag_q && !(wr_warn && !pwdata[0]) && !(wr_clr && pwdata[EVT_WARN_BIT]) |=> flag_q
    ) else $error("warn flag dropped on its own");

    chk_freeze: assert property (
        dbg_halt && halt_freeze_cfg && !wr_ctrl |=> $stable(cnt_q) && $stable(pre_q)
    ) else $error("counter moved while frozen");

    chk_flag_set: assert property (
        tick && !wr_ctrl && cnt_q == WARN_COUNT + 7'h01 |=> flag_q && cnt_q == WARN_COUNT
    ) else $error("warn flag not set at 40h");

    chk_ewe_sticky: assert property (
        ewe_q |=> ewe_q
    ) else $error("warn enable cleared");

    chk_reset_pulse: assert property (
        rst_d |=> wdg_reset_req && evt[EVT_FAULT_BIT]
    ) else $error("reset pulse malformed");

    chk_apb_answer: assert property (
        psel && penable && !pready |=> pready ##1 !pready
    ) else $error("apb answer not one cycle");

    // an unmapped access still ends on time, with the error flag up
    chk_apb_error: assert property (
        psel && penable && !pready && !mapped |=> pslverr && pready
    ) else $error("unmapped access without error");

    chk_tick_restart: assert property (
        tick |=> pre_q == '0
    ) else $error("prescaler did not restart after a tick");

    chk_phase_keep: assert property (
        wr_ctrl && !tick && !(dbg_halt && halt_freeze_cfg) && pre_q < pre_last
            |=> pre_q == $past(pre_q) + 1'b1
    ) else $error("counter write disturbed the prescaler phase");

    chk_ctrl_load: assert property (
        wr_ctrl |=> cnt_q == $past(pwdata[6:0])
    ) else $error("counter write not loaded");

    chk_arm_set: assert property (
        wr_ctrl && pwdata[CTRL_ARM_BIT] |=> arm_q
    ) else $error("arm latch not set by write");

    // an unarmed block with no arming write never asks for a system reset
    chk_armed_only: assert property (
        !arm_q && !(wr_ctrl && pwdata[CTRL_ARM_BIT]) |=> !wdg_reset_req
    ) else $error("reset request while unarmed");

    chk_irq_quiet: assert property (
        !flag_q && !fault_q |=> !irq
    ) else $error("interrupt without a cause");

    chk_warn_gate: assert property (
        !ewe_q && !fault_q |=> !irq
    ) else $error("warn interrupt without warn enable");

    chk_flag_clear: assert property (
        flag_q && wr_warn && !pwdata[0]
            && !(tick && cnt_q == WARN_COUNT + 7'h01) |=> !flag_q
    ) else $error("warn flag not cleared by zero write");

    chk_flag_one: assert property (
        !flag_q && wr_warn && pwdata[0] && !tick |=> !flag_q
    ) else $error("warn flag set by a one write");

    chk_ewe_set: assert property (
        wr_cfg && pwdata[CFG_EWE_BIT] |=> ewe_q
    ) else $error("warn enable not set by write");
endmodule

// file: wwd_pkg.sv
// constants for the window watchdog: register map, fields, reset values
package wwd_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_WARN = 8'h08;
    localparam logic [7:0] OFF_EVT = 8'h0c;
    localparam logic [7:0] OFF_CLR = 8'h10;
    localparam logic [7:0] OFF_EN = 8'h14;
    // field positions
    localparam int CTRL_ARM_BIT = 7;
    localparam int CFG_EWE_BIT = 9;
    localparam int CFG_DIV_LSB = 7;
    localparam int CNT_MSB_BIT = 6;
    localparam int EVT_WARN_BIT = 0;
    localparam int EVT_FAULT_BIT = 1;
    localparam int EVT_W = 2;
    // reset values
    localparam logic [6:0] COUNT_RST = 7'h7f;
    localparam logic [6:0] WINDOW_RST = 7'h7f;
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [EVT_W-1:0] EVT_EN_RST = 2'h0;
    // counter values of interest
    localparam logic [6:0] WARN_COUNT = 7'h40;
    localparam logic [6:0] LAST_SAFE = 7'h3f;
    // base prescale in bus clock cycles (one tick at divider code 00)
    localparam int PRESC_BASE = 4096;
    localparam int PRESC_W = 15;
endpackage

// file: testbench.sv
// self-checking testbench for the window watchdog over its apb port
`timescale 1ns/100ps
module testbench;
    import wwd_pkg::*;
    // short prescale base keeps the run brief; every tick-length wait below derives from it
    localparam int BASE = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic dbg_halt = 1'b0;
    logic halt_freeze_cfg = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq, wdg_reset_req;
    int fail_count = 0;
    int tests_run = 0;
    int rst_seen = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic err;
    logic [6:0] c;

    window_watchdog #(.BASE_CYCLES(BASE)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .dbg_halt(dbg_halt), .halt_freeze_cfg(halt_freeze_cfg), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .wdg_reset_req(wdg_reset_req));

    always #20 pclk = ~pclk;

    // count reset-request cycles and cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (wdg_reset_req === 1'b1) rst_seen++;
        if (cyc == 60000) begin
            fail_count++;
            results();
        end
    end

    task results;
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high, however long
    // that takes: only the cycle ceiling ends a stuck wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read until the masked value shows up, bounded
    task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (((rd & m) !== v) && n < 400);
        chk(rd & m, v);
    endtask

    task do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rst_seen = 0;
    endtask

    // expected count after load c and a wait of four ticks: phase is unknown
    function automatic logic in_span(input logic [6:0] got, input logic [6:0] c0);
        return (got == c0 - 7'h4) || (got == c0 - 7'h5);
    endfunction

    initial begin
        void'($urandom(32'hbeaa));
        do_reset();
        // reset values and an unmapped place
        apb(1'b0, OFF_CFG, 32'h0);
        chk(rd, 32'h7f);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd & 32'h80, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // unarmed: counter runs free, flag sets without enable, no reset, no irq
        apb(1'b1, OFF_EN, 32'h3);
        poll(OFF_EVT, 32'h1, 32'h1);
        chk({irq, 7'h0, rst_seen[23:0]}, 32'h0);
        // arm, then a zero arm bit must not disarm; early refresh resets
        do_reset();
        apb(1'b1, OFF_CTRL, 32'hff);
        apb(1'b1, OFF_CTRL, 32'h7f);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd & 32'h80, 32'h80);
        apb(1'b1, OFF_CFG, 32'h50);
        apb(1'b1, OFF_CTRL, 32'hff);
        repeat (3) @(posedge pclk);
        chk(rst_seen, 1);
        // deliberate software reset: armed write with msb clear
        do_reset();
        apb(1'b1, OFF_CTRL, 32'hff);
        apb(1'b1, OFF_CTRL, 32'hbf);
        repeat (3) @(posedge pclk);
        chk(rst_seen, 1);
        // legal refresh inside the window, then run out to the warning and rollover
        do_reset();
        apb(1'b1, OFF_EN, 32'h3);
        apb(1'b1, OFF_CFG, 32'h250);
        apb(1'b1, OFF_CFG, 32'h050);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, OFF_CFG, 32'h0);
        chk(rd, 32'h250);
        apb(1'b1, OFF_CTRL, 32'hff);
        poll(OFF_CTRL, 32'h7f, 32'h4f);
        apb(1'b1, OFF_CTRL, 32'hff);
        chk(rst_seen, 0);
        poll(OFF_CTRL, 32'h7f, 32'h40);
        chk({irq, rst_seen[6:0]}, 8'h80);
        apb(1'b1, OFF_WARN, 32'h1);
        apb(1'b0, OFF_WARN, 32'h0);
        chk(rd, 32'h1);
        repeat (2 * BASE) @(posedge pclk);
        chk(rst_seen, 1);
        apb(1'b1, OFF_WARN, 32'h0);
        apb(1'b1, OFF_CLR, 32'h2);
        apb(1'b0, OFF_EVT, 32'h0);
        chk({irq, rd[1:0]}, 3'h0);
        // every divider code, random loads: phase survives the counter write
        for (int d = 0; d < 4; d++) begin
            do_reset();
            apb(1'b1, OFF_CFG, (d << 7) | 32'h7f);
            c = 7'h48 + 7'($urandom % 56);
            apb(1'b1, OFF_CTRL, {25'h0, c});
            repeat (4 * (BASE << d)) @(posedge pclk);
            apb(1'b0, OFF_CTRL, 32'h0);
            chk(in_span(rd[6:0], c), 1'b1);
        end
        // debug halt freezes or runs as selected
        do_reset();
        halt_freeze_cfg <= 1'b1;
        dbg_halt <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h70);
        repeat (5 * BASE) @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h70);
        halt_freeze_cfg <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h70);
        repeat (4 * BASE) @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(in_span(rd[6:0], 7'h70), 1'b1);
        results();
    end
endmodule
